// File: hdl/tsbss_sequencer.sv
// design: two-stage boot strap sequencer with classic wishbone register slave
// Function
// - after power-on the processor starts at the first_rom_stub, which checks the flag
// - power-on reset sets the first-boot flag
// - secure registers answer only during the initialisation pass, else blocked
// - with flag set the processor runs initialisation code first
// - end of initialisation clears flag and switches processor and dma master ids
// - after the clear the processor is reset again without power-on reset
// - second pass reads the flag cleared and runs with the new ids
// - second pass runs stub and non-secure code, then the application
// - from application start until power cycle, secure access is denied
// - first pass has unrestricted register access, only second pass runs user code
// - strap levels are sampled into a register before leaving reset
// - captured straps select boot flow and debug and serial pin mapping
// - strap two high, one and zero low selects serial_load_mode
// - serial_load_mode waits for code with no timeout
// - serial_load_mode puts the debug port in four-wire form
// - strap zero high, others low gives functional boot with two-wire debug
// - all straps low gives functional boot with four-wire debug
// - strap pins zero and one stay dedicated and are never released
//
// The register offsets and the Wishbone slave port were decided locally.
`timescale 1ns/1ns
`default_nettype none

module tsbss_sequencer
  import tsbss_pkg::*;
#(
  parameter int unsigned SETTLE_CYC = STRAP_SETTLE_CYC,
  parameter int unsigned SELF_RST_CYC = SELF_RESET_CYC
) (
  // clock and power-on reset
  input wire logic I_CLK,
  input wire logic I_RESETN,
  // strap pins, asynchronous
  input wire logic I_STRAP_PIN_ZERO,
  input wire logic I_STRAP_PIN_ONE,
  input wire logic I_STRAP_PIN_TWO,
  // wishbone slave
  input wire logic I_WB_CYC,
  input wire logic I_WB_STB,
  input wire logic I_WB_WE,
  input wire logic [7:0] I_WB_ADR,
  input wire logic [3:0] I_WB_SEL,
  input wire logic [31:0] I_WB_DAT,
  output logic [31:0] O_WB_DAT,
  output logic O_WB_ACK,
  output logic O_WB_ERR,
  // processor control
  output logic O_CPU_RESETN,
  output logic [31:0] O_BOOT_ADDR,
  output logic O_FIRST_BOOT,
  output logic O_SECURE_OPEN,
  output logic O_USER_CODE_OK,
  output logic [3:0] O_CPU_MASTER_ID,
  output logic [3:0] O_DMA_MASTER_ID,
  // boot mode and pin mapping
  output logic O_SERIAL_LOAD_MODE,
  output logic O_TWO_WIRE_DEBUG_MODE,
  output logic O_FOUR_WIRE_DEBUG_MODE,
  output logic O_STRAP_PIN_TWO_FREE,
  output logic O_STRAP_ERROR
);

  // elaboration checks on counts
  if (SETTLE_CYC < 1 || SETTLE_CYC > 255) begin : g_bad_settle
    $error("SETTLE_CYC must lie in 1..255");
  end
  if (SELF_RST_CYC < 1 || SELF_RST_CYC > 255) begin : g_bad_self_rst
    $error("SELF_RST_CYC must lie in 1..255");
  end

  localparam logic [7:0] SETTLE_LAST = 8'(SETTLE_CYC - 1);
  localparam logic [7:0] SELF_RST_LAST = 8'(SELF_RST_CYC - 1);

  tsbss_state_t state_q;
  tsbss_state_t state_d;
  tsbss_strap_t strap_meta_q;
  tsbss_strap_t strap_sync_q;
  tsbss_strap_t strap_prev_q;
  tsbss_strap_t strap_q;
  logic [2:0] fill_q;
  tsbss_mode_t mode_q;
  tsbss_mid_t app_mid_q;
  tsbss_mid_t active_mid_q;
  logic [7:0] cnt_q;
  logic flag_q;
  logic cpu_run_q;
  logic ack_q;
  logic err_q;
  logic [31:0] rdata_q;
  logic strap_valid;
  logic secure_open;
  logic bus_req;
  logic adr_mapped;
  logic adr_secure;
  logic wr_ok;
  logic done_wr;
  logic mid_wr;

  // strap synchroniser; the first stage feeds only the second
  always_ff @(posedge I_CLK or negedge I_RESETN) begin
    if (!I_RESETN) begin
      strap_meta_q <= '0;
      strap_sync_q <= '0;
      strap_prev_q <= '0;
      fill_q <= '0;
    end else begin
      strap_meta_q <= '{two: I_STRAP_PIN_TWO, one: I_STRAP_PIN_ONE, zero: I_STRAP_PIN_ZERO};
      strap_sync_q <= strap_meta_q;
      strap_prev_q <= strap_sync_q;
      // compare stages hold real pin levels only from the third edge on;
      // a short settle count would otherwise capture the reset zeros
      fill_q <= {fill_q[1:0], 1'b1};
    end
  end

  // only the three documented encodings boot; anything else is reserved
  assign strap_valid = (strap_q == SERIAL_LOAD_CONFIG) || (strap_q == TWO_WIRE_FUNCTIONAL_CONFIG)
    || (strap_q == FOUR_WIRE_FUNCTIONAL_CONFIG);

  // secure region is open only while the initialisation pass runs
  assign secure_open = (state_q == ST_INIT_PASS);

  // wishbone request decode
  assign bus_req = I_WB_CYC && I_WB_STB && !ack_q && !err_q;
  assign adr_mapped = (I_WB_ADR == REG_STATUS_OFS) || (I_WB_ADR == REG_STRAP_OFS)
    || (I_WB_ADR == REG_INIT_CTRL_OFS) || (I_WB_ADR == REG_MASTER_ID_OFS);
  assign adr_secure = (I_WB_ADR == REG_INIT_CTRL_OFS) || (I_WB_ADR == REG_MASTER_ID_OFS);
  assign wr_ok = bus_req && I_WB_WE && adr_mapped && (!adr_secure || secure_open) && I_WB_SEL[0];
  assign done_wr = wr_ok && (I_WB_ADR == REG_INIT_CTRL_OFS) && I_WB_DAT[INIT_CTRL_DONE_BIT];
  assign mid_wr = wr_ok && (I_WB_ADR == REG_MASTER_ID_OFS);

  // sequencer next state
  always_comb begin
    state_d = state_q;
    case (state_q)
      ST_SENSE: begin
        // straps must hold steady for the settle time before capture
        if (fill_q[2] && strap_sync_q == strap_prev_q && cnt_q == SETTLE_LAST) begin
          state_d = ST_DECODE;
        end
      end
      ST_DECODE: begin
        if (strap_valid) begin
          state_d = ST_INIT_PASS;
        end else begin
          state_d = ST_STRAP_ERR;
        end
      end
      ST_INIT_PASS: begin
        if (done_wr) begin
          state_d = ST_SELF_RST;
        end
      end
      ST_SELF_RST: begin
        if (cnt_q == SELF_RST_LAST) begin
          state_d = ST_APP_PASS;
        end
      end
      // application pass and error hold last until power is cycled
      ST_APP_PASS: state_d = ST_APP_PASS;
      ST_STRAP_ERR: state_d = ST_STRAP_ERR;
      default: state_d = ST_SENSE;
    endcase
  end

  // state register
  always_ff @(posedge I_CLK or negedge I_RESETN) begin
    if (!I_RESETN) begin
      state_q <= ST_SENSE;
    end else begin
      state_q <= state_d;
    end
  end

  // shared counter: strap settle, then self-reset width; no load timeout exists
  always_ff @(posedge I_CLK or negedge I_RESETN) begin
    if (!I_RESETN) begin
      cnt_q <= '0;
    end else if (state_q == ST_SENSE) begin
      if (!fill_q[2] || strap_sync_q != strap_prev_q) begin
        cnt_q <= '0;
      end else if (cnt_q != SETTLE_LAST) begin
        cnt_q <= cnt_q + 8'h01;
      end
    end else if (state_q == ST_SELF_RST) begin
      cnt_q <= cnt_q + 8'h01;
    end else begin
      cnt_q <= '0;
    end
  end

  // strap capture register, written once before the processor leaves reset
  always_ff @(posedge I_CLK or negedge I_RESETN) begin
    if (!I_RESETN) begin
      strap_q <= '0;
    end else if (state_q == ST_SENSE && state_d == ST_DECODE) begin
      strap_q <= strap_sync_q;
    end
  end

  // boot mode and pin mapping from the captured straps
  always_ff @(posedge I_CLK or negedge I_RESETN) begin
    if (!I_RESETN) begin
      mode_q <= '0;
    end else if (state_q == ST_DECODE) begin
      mode_q.serial_load_mode <= (strap_q == SERIAL_LOAD_CONFIG);
      mode_q.two_wire_debug_mode <= (strap_q == TWO_WIRE_FUNCTIONAL_CONFIG);
      // serial load also uses the four-wire debug arrangement
      mode_q.four_wire_debug_mode <= (strap_q == FOUR_WIRE_FUNCTIONAL_CONFIG)
        || (strap_q == SERIAL_LOAD_CONFIG);
    end
  end

  // first-boot flag: set by power-on reset, cleared once by the done write
  always_ff @(posedge I_CLK or negedge I_RESETN) begin
    if (!I_RESETN) begin
      flag_q <= 1'b1;
    end else if (state_q == ST_INIT_PASS && done_wr) begin
      flag_q <= 1'b0;
    end
  end

  // second-pass master ids, secure and writable only in the first pass
  always_ff @(posedge I_CLK or negedge I_RESETN) begin
    if (!I_RESETN) begin
      app_mid_q <= '{dma: APP_DMA_MID_RST, cpu: APP_CPU_MID_RST};
    end else if (mid_wr) begin
      app_mid_q.cpu <= I_WB_DAT[MASTER_ID_CPU_LSB +: 4];
      app_mid_q.dma <= I_WB_DAT[MASTER_ID_DMA_LSB +: 4];
    end
  end

  // active ids switch together with the flag clear
  always_ff @(posedge I_CLK or negedge I_RESETN) begin
    if (!I_RESETN) begin
      active_mid_q <= '{dma: INIT_DMA_MID_RST, cpu: INIT_CPU_MID_RST};
    end else if (state_q == ST_INIT_PASS && done_wr) begin
      active_mid_q <= mid_wr ? tsbss_mid_t'({I_WB_DAT[MASTER_ID_DMA_LSB +: 4], I_WB_DAT[MASTER_ID_CPU_LSB +: 4]})
        : app_mid_q;
    end
  end

  // processor run enable; self reset drops it between the passes
  always_ff @(posedge I_CLK or negedge I_RESETN) begin
    if (!I_RESETN) begin
      cpu_run_q <= 1'b0;
    end else begin
      // the processor starts at the stub in both passes; the stub reads the flag
      cpu_run_q <= (state_d == ST_INIT_PASS) || (state_d == ST_APP_PASS);
    end
  end

  // wishbone answer: one cycle after the request, error for unmapped or blocked access
  always_ff @(posedge I_CLK or negedge I_RESETN) begin
    if (!I_RESETN) begin
      ack_q <= 1'b0;
      err_q <= 1'b0;
    end else begin
      ack_q <= bus_req && adr_mapped && (!adr_secure || secure_open);
      err_q <= bus_req && (!adr_mapped || (adr_secure && !secure_open));
    end
  end

  // read data, captured with the answer
  always_ff @(posedge I_CLK or negedge I_RESETN) begin
    if (!I_RESETN) begin
      rdata_q <= '0;
    end else if (bus_req) begin
      rdata_q <= '0;
      if (!I_WB_WE) begin
        case (I_WB_ADR)
          REG_STATUS_OFS: begin
            // flag stays readable in every pass so the stub can pick its path
            rdata_q[STATUS_FLAG_BIT] <= flag_q;
            rdata_q[STATUS_SECURE_BIT] <= secure_open;
            rdata_q[STATUS_CPU_RUN_BIT] <= cpu_run_q;
            rdata_q[STATUS_ERROR_BIT] <= (state_q == ST_STRAP_ERR);
            rdata_q[STATUS_STATE_LSB +: 6] <= state_q;
          end
          REG_STRAP_OFS: rdata_q[2:0] <= strap_q;
          REG_INIT_CTRL_OFS: rdata_q[INIT_CTRL_DONE_BIT] <= !flag_q;
          REG_MASTER_ID_OFS: begin
            if (secure_open) begin
              rdata_q[7:0] <= app_mid_q;
            end
          end
          default: rdata_q <= '0;
        endcase
      end
    end
  end

  // outputs
  assign O_WB_DAT = rdata_q;
  assign O_WB_ACK = ack_q;
  assign O_WB_ERR = err_q;
  assign O_CPU_RESETN = cpu_run_q;
  assign O_BOOT_ADDR = FIRST_ROM_STUB_ADDR;
  assign O_FIRST_BOOT = flag_q;
  assign O_SECURE_OPEN = secure_open;
  assign O_USER_CODE_OK = (state_q == ST_APP_PASS);
  assign O_CPU_MASTER_ID = active_mid_q.cpu;
  assign O_DMA_MASTER_ID = active_mid_q.dma;
  assign O_SERIAL_LOAD_MODE = mode_q.serial_load_mode;
  assign O_TWO_WIRE_DEBUG_MODE = mode_q.two_wire_debug_mode;
  assign O_FOUR_WIRE_DEBUG_MODE = mode_q.four_wire_debug_mode;
  // only pin two is handed back; pins zero and one have no release output
  assign O_STRAP_PIN_TWO_FREE = (state_q == ST_INIT_PASS) || (state_q == ST_SELF_RST)
    || (state_q == ST_APP_PASS);
  assign O_STRAP_ERROR = (state_q == ST_STRAP_ERR);

  // checks

  a_flag_at_por: assert property (@(posedge I_CLK) disable iff (!I_RESETN)
    (state_q == ST_SENSE || state_q == ST_DECODE) |-> (flag_q && !O_CPU_RESETN))
    else $error("flag not set or processor running before straps decoded");

  a_strap_capture: assert property (@(posedge I_CLK) disable iff (!I_RESETN)
    (state_q == ST_SENSE && state_d == ST_DECODE) |=> (strap_q == $past(strap_sync_q) && !O_CPU_RESETN))
    else $error("strap value not captured before reset release");

  a_secure_block: assert property (@(posedge I_CLK) disable iff (!I_RESETN)
    (bus_req && adr_secure && !secure_open) |=> (O_WB_ERR && !O_WB_ACK && $stable(app_mid_q)))
    else $error("secure access outside first pass not blocked");

  a_done_switch: assert property (@(posedge I_CLK) disable iff (!I_RESETN)
    (state_q == ST_INIT_PASS && done_wr) |=> (!flag_q && state_q == ST_SELF_RST && !O_CPU_RESETN
      && {O_DMA_MASTER_ID, O_CPU_MASTER_ID} == $past(app_mid_q)))
    else $error("first pass end did not clear flag and reset processor");

  a_self_rst_width: assert property (@(posedge I_CLK) disable iff (!I_RESETN)
    (state_q == ST_SELF_RST) |-> (cnt_q <= SELF_RST_LAST && !O_CPU_RESETN))
    else $error("self reset pulse exceeded its width");

  a_app_entry: assert property (@(posedge I_CLK) disable iff (!I_RESETN)
    (state_q == ST_SELF_RST && cnt_q == SELF_RST_LAST) |=> ##1 (O_CPU_RESETN && !O_FIRST_BOOT))
    else $error("second pass did not start with flag cleared");

  a_app_locked: assert property (@(posedge I_CLK) disable iff (!I_RESETN)
    (state_q == ST_APP_PASS) |=> (state_q == ST_APP_PASS && !O_SECURE_OPEN && O_USER_CODE_OK))
    else $error("application pass left or secure region reopened");

  a_mode_map: assert property (@(posedge I_CLK) disable iff (!I_RESETN)
    (state_q == ST_INIT_PASS) |-> (O_SERIAL_LOAD_MODE == (strap_q == SERIAL_LOAD_CONFIG)
      && O_FOUR_WIRE_DEBUG_MODE == !strap_q.zero && O_TWO_WIRE_DEBUG_MODE == strap_q.zero))
    else $error("boot mode does not match captured straps");

  a_err_hold: assert property (@(posedge I_CLK) disable iff (!I_RESETN)
    (state_q == ST_DECODE && !strap_valid) |=> (O_STRAP_ERROR && !O_CPU_RESETN) [*3])
    else $error("reserved strap code did not hold reset");

  a_flag_one_way: assert property (@(posedge I_CLK) disable iff (!I_RESETN)
    !flag_q |=> !flag_q)
    else $error("first-boot flag set again without power-on reset");

  a_user_gate: assert property (@(posedge I_CLK) disable iff (!I_RESETN)
    O_USER_CODE_OK |-> (!O_FIRST_BOOT && !O_SECURE_OPEN && O_CPU_RESETN))
    else $error("user code allowed while first pass state still visible");

  a_lane_ignored: assert property (@(posedge I_CLK) disable iff (!I_RESETN)
    (bus_req && I_WB_WE && !I_WB_SEL[0]) |=> ($stable(flag_q) && $stable(app_mid_q)))
    else $error("write without low lane changed flag or ids");

  a_pin_two_held: assert property (@(posedge I_CLK) disable iff (!I_RESETN)
    (state_q == ST_SENSE || state_q == ST_DECODE || state_q == ST_STRAP_ERR) |-> !O_STRAP_PIN_TWO_FREE)
    else $error("strap pin two released before boot started");

  a_ack_single: assert property (@(posedge I_CLK) disable iff (!I_RESETN)
    (O_WB_ACK || O_WB_ERR) |=> !(O_WB_ACK || O_WB_ERR))
    else $error("bus answer longer than one cycle");

endmodule : tsbss_sequencer

`default_nettype wire

// File: pkg/tsbss_pkg.sv
// package: constants, states and carriers of the two-stage boot strap sequencer
package tsbss_pkg;

  // clock and timing
  localparam int unsigned CLK_PERIOD_NS = 40;
  localparam int unsigned STRAP_SETTLE_NS = 1000;
  localparam int unsigned STRAP_SETTLE_CYC = (STRAP_SETTLE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int unsigned SELF_RESET_NS = 200;
  localparam int unsigned SELF_RESET_CYC = (SELF_RESET_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;

  // register byte offsets; index 2 and up form the secure region
  localparam logic [7:0] REG_STATUS_OFS = 8'h00;
  localparam logic [7:0] REG_STRAP_OFS = 8'h04;
  localparam logic [7:0] REG_INIT_CTRL_OFS = 8'h08;
  localparam logic [7:0] REG_MASTER_ID_OFS = 8'h0C;

  // field positions
  localparam int unsigned STATUS_FLAG_BIT = 0;
  localparam int unsigned STATUS_SECURE_BIT = 1;
  localparam int unsigned STATUS_CPU_RUN_BIT = 2;
  localparam int unsigned STATUS_ERROR_BIT = 3;
  localparam int unsigned STATUS_STATE_LSB = 8;
  localparam int unsigned INIT_CTRL_DONE_BIT = 0;
  localparam int unsigned MASTER_ID_CPU_LSB = 0;
  localparam int unsigned MASTER_ID_DMA_LSB = 4;

  // strap encodings, bit order {two, one, zero}
  localparam logic [2:0] SERIAL_LOAD_CONFIG = 3'h4;
  localparam logic [2:0] TWO_WIRE_FUNCTIONAL_CONFIG = 3'h1;
  localparam logic [2:0] FOUR_WIRE_FUNCTIONAL_CONFIG = 3'h0;

  // reset values
  localparam logic [3:0] INIT_CPU_MID_RST = 4'h0;
  localparam logic [3:0] INIT_DMA_MID_RST = 4'h1;
  localparam logic [3:0] APP_CPU_MID_RST = 4'h2;
  localparam logic [3:0] APP_DMA_MID_RST = 4'h3;
  localparam logic [31:0] FIRST_ROM_STUB_ADDR = 32'h0000_0000;

  // sequencer states, one-hot
  typedef enum logic [5:0] {
    ST_SENSE = 6'h01,
    ST_DECODE = 6'h02,
    ST_INIT_PASS = 6'h04,
    ST_SELF_RST = 6'h08,
    ST_APP_PASS = 6'h10,
    ST_STRAP_ERR = 6'h20
  } tsbss_state_t;

  // captured power_up_strap_sense levels
  typedef struct packed {
    logic two;
    logic one;
    logic zero;
  } tsbss_strap_t;

  // bus master identities of processor and dma engine
  typedef struct packed {
    logic [3:0] dma;
    logic [3:0] cpu;
  } tsbss_mid_t;

  // decoded boot mode
  typedef struct packed {
    logic serial_load_mode;
    logic two_wire_debug_mode;
    logic four_wire_debug_mode;
  } tsbss_mode_t;

endpackage : tsbss_pkg

// File: tb/tb_top.sv
// testbench: strap decode and two-pass boot of the sequencer
`timescale 1ns/1ns
`default_nettype none
module tb_top
  import tsbss_pkg::*;
;
  typedef struct packed {logic [2:0] cfg; logic ser; logic two; logic four; logic err;} tsbss_row_t;
  // short counts keep each power cycle brief
  localparam int unsigned SETTLE = 2;
  localparam int unsigned SELF_RST = 2;
  logic clk = 1'b0;
  logic resetn = 1'b0;
  logic [2:0] fit = 3'h0;
  logic app_en = 1'b0;
  logic app_out = 1'b0;
  logic cyc = 1'b0;
  logic stb = 1'b0;
  logic we = 1'b0;
  logic [7:0] adr = 8'h00;
  logic [3:0] sel = 4'hF;
  logic [31:0] wdat = 32'h0;
  logic pin_zero, pin_one, pin_two, ack, err, cpu_resetn, first_boot, secure_open, user_ok;
  logic ser, two, four, pin_two_free, strap_err;
  logic [31:0] rd, boot_addr;
  logic [3:0] cpu_mid, dma_mid;
  int fails = 0;
  int check_count = 0;
  int drops = 0;
  logic cpu_prev = 1'b0;
  tsbss_row_t rows [4] = '{'{SERIAL_LOAD_CONFIG, 1'b1, 1'b0, 1'b1, 1'b0},
    '{TWO_WIRE_FUNCTIONAL_CONFIG, 1'b0, 1'b1, 1'b0, 1'b0},
    '{FOUR_WIRE_FUNCTIONAL_CONFIG, 1'b0, 1'b0, 1'b1, 1'b0}, '{3'h7, 1'b0, 1'b0, 1'b0, 1'b1}};

  always #20 clk = ~clk;

  tsbss_strap_board i_tsbss_strap_board (.i_fit(fit), .i_pin_two_free(pin_two_free), .i_app_out_en(app_en),
    .i_app_out(app_out), .o_pin_zero(pin_zero), .o_pin_one(pin_one), .o_pin_two(pin_two));

  tsbss_sequencer #(.SETTLE_CYC(SETTLE), .SELF_RST_CYC(SELF_RST)) i_tsbss_sequencer (.I_CLK(clk),
    .I_RESETN(resetn), .I_STRAP_PIN_ZERO(pin_zero), .I_STRAP_PIN_ONE(pin_one), .I_STRAP_PIN_TWO(pin_two),
    .I_WB_CYC(cyc), .I_WB_STB(stb), .I_WB_WE(we), .I_WB_ADR(adr), .I_WB_SEL(sel), .I_WB_DAT(wdat),
    .O_WB_DAT(rd), .O_WB_ACK(ack), .O_WB_ERR(err), .O_CPU_RESETN(cpu_resetn), .O_BOOT_ADDR(boot_addr),
    .O_FIRST_BOOT(first_boot), .O_SECURE_OPEN(secure_open), .O_USER_CODE_OK(user_ok),
    .O_CPU_MASTER_ID(cpu_mid), .O_DMA_MASTER_ID(dma_mid), .O_SERIAL_LOAD_MODE(ser),
    .O_TWO_WIRE_DEBUG_MODE(two), .O_FOUR_WIRE_DEBUG_MODE(four), .O_STRAP_PIN_TWO_FREE(pin_two_free),
    .O_STRAP_ERROR(strap_err));

  // counts processor resets that happen without a power-on reset
  always @(negedge clk) begin
    if (resetn === 1'b1 && cpu_prev === 1'b1 && cpu_resetn === 1'b0) drops++;
    cpu_prev = cpu_resetn;
  end

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    check_count++;
    if (got !== exp) begin
      fails++;
      $display("mismatch at %0t: got %h expected %h", $time, got, exp);
    end
  endtask : chk

  // one classic cycle; answer and read data taken at the rising edge that samples ack or err high
  task automatic acc(input logic w, input logic [7:0] a, input logic [31:0] d, input logic [3:0] s,
                     input logic [31:0] x, input logic xe);
    int n;
    n = 0;
    @(posedge clk);
    cyc <= 1'b1;
    stb <= 1'b1;
    we <= w;
    adr <= a;
    wdat <= d;
    sel <= s;
    do begin
      @(posedge clk);
      n++;
    end while (ack !== 1'b1 && err !== 1'b1 && n < 50);
    if (ack !== 1'b1 && err !== 1'b1) fails++;
    chk({31'h0, err}, {31'h0, xe});
    if (xe === 1'b0 && w === 1'b0) chk(rd, x);
    cyc <= 1'b0;
    stb <= 1'b0;
    @(negedge clk);
  endtask : acc

  // power cycle with a given resistor fit, then wait for boot or error
  task automatic por(input logic [2:0] f);
    int n;
    @(posedge clk);
    resetn <= 1'b0;
    fit <= f;
    app_en <= 1'b0;
    repeat (8) @(posedge clk);
    chk(first_boot, 1'b1);
    chk(cpu_resetn, 1'b0);
    resetn <= 1'b1;
    n = 0;
    while (cpu_resetn !== 1'b1 && strap_err !== 1'b1 && n < 100) begin
      @(negedge clk);
      n++;
    end
    if (cpu_resetn !== 1'b1 && strap_err !== 1'b1) fails++;
  endtask : por

  task automatic two_pass(input logic [2:0] f);
    int d0;
    int n;
    chk({first_boot, secure_open, user_ok}, 3'b110);
    chk(boot_addr, FIRST_ROM_STUB_ADDR);
    chk({dma_mid, cpu_mid}, {INIT_DMA_MID_RST, INIT_CPU_MID_RST});
    acc(1'b0, REG_STATUS_OFS, 32'h0, 4'hF, 32'h0000_0407, 1'b0);
    acc(1'b0, REG_STRAP_OFS, 32'h0, 4'hF, {29'h0, f}, 1'b0);
    acc(1'b0, REG_INIT_CTRL_OFS, 32'h0, 4'hF, 32'h0, 1'b0);
    acc(1'b0, REG_MASTER_ID_OFS, 32'h0, 4'hF, {24'h0, APP_DMA_MID_RST, APP_CPU_MID_RST}, 1'b0);
    acc(1'b1, REG_MASTER_ID_OFS, 32'h75, 4'hF, 32'h0, 1'b0);
    // done written without the low lane must not end the pass
    acc(1'b1, REG_INIT_CTRL_OFS, 32'h1, 4'hE, 32'h0, 1'b0);
    chk(first_boot, 1'b1);
    d0 = drops;
    acc(1'b1, REG_INIT_CTRL_OFS, 32'h1, 4'hF, 32'h0, 1'b0);
    n = 0;
    while (cpu_resetn !== 1'b1 && n < 50) begin
      @(negedge clk);
      n++;
    end
    if (cpu_resetn !== 1'b1) fails++;
    chk(drops, d0 + 1);
    chk({first_boot, secure_open, user_ok, pin_two_free}, 4'b0011);
    chk({dma_mid, cpu_mid}, 8'h75);
    acc(1'b0, REG_STATUS_OFS, 32'h0, 4'hF, 32'h0000_1004, 1'b0);
    acc(1'b0, REG_MASTER_ID_OFS, 32'h0, 4'hF, 32'h0, 1'b1);
    acc(1'b1, REG_MASTER_ID_OFS, 32'h11, 4'hF, 32'h0, 1'b1);
    acc(1'b1, REG_INIT_CTRL_OFS, 32'h1, 4'hF, 32'h0, 1'b1);
    acc(1'b0, 8'h10, 32'h0, 4'hF, 32'h0, 1'b1);
    chk({dma_mid, cpu_mid, cpu_resetn}, {8'h75, 1'b1});
    // app now drives pin two against its resistor; the captured straps must hold
    @(posedge clk);
    app_en <= 1'b1;
    app_out <= ~f[2];
    repeat (10) @(negedge clk);
    acc(1'b0, REG_STRAP_OFS, 32'h0, 4'hF, {29'h0, f}, 1'b0);
  endtask : two_pass

  task automatic wrap_up;
    $display("comparisons %0d, mismatches %0d", check_count, fails);
    if (fails == 0 && check_count > 0)
      $display("Finished cleanly");
    else
      $display("Finished with errors");
    $finish;
  endtask : wrap_up

  // watchdog, well beyond the few hundred cycles the tests take
  initial begin
    repeat (20000) @(posedge clk);
    fails++;
    wrap_up();
  end

  initial begin
    // table of strap fits against decoded mode
    foreach (rows[i]) begin
      por(rows[i].cfg);
      chk(strap_err, rows[i].err);
      if (rows[i].err === 1'b0) begin
        chk({ser, two, four}, {rows[i].ser, rows[i].two, rows[i].four});
        two_pass(rows[i].cfg);
        chk({ser, two, four}, {rows[i].ser, rows[i].two, rows[i].four});
      end
    end
    // reserved fit holds the processor and keeps the secure region shut
    por(3'h2);
    repeat (40) @(negedge clk);
    chk({strap_err, cpu_resetn, user_ok}, 3'b100);
    acc(1'b0, REG_STATUS_OFS, 32'h0, 4'hF, 32'h0000_2009, 1'b0);
    acc(1'b0, REG_MASTER_ID_OFS, 32'h0, 4'hF, 32'h0, 1'b1);
    // power cycle in mid first pass restores flag and identities
    por(TWO_WIRE_FUNCTIONAL_CONFIG);
    acc(1'b1, REG_MASTER_ID_OFS, 32'h55, 4'hF, 32'h0, 1'b0);
    por(TWO_WIRE_FUNCTIONAL_CONFIG);
    chk({strap_err, first_boot, dma_mid, cpu_mid}, 10'h110);
    acc(1'b0, REG_MASTER_ID_OFS, 32'h0, 4'hF, 32'h32, 1'b0);
    wrap_up();
  end
endmodule : tb_top
`default_nettype wire

// File: tb/tsbss_strap_board.sv
// partner model: board strap resistors and the application's later use of strap pin two
`timescale 1ns/1ns
`default_nettype none
module tsbss_strap_board
  import tsbss_pkg::*;
(
  // resistor fit and application drive
  input wire logic [2:0] i_fit,
  input wire logic i_pin_two_free,
  input wire logic i_app_out_en,
  input wire logic i_app_out,
  // strap pins
  output logic o_pin_zero,
  output logic o_pin_one,
  output logic o_pin_two
);
  // pins zero and one only ever see their resistors, they carry analogue test duty
  assign o_pin_zero = i_fit[0];
  assign o_pin_one = i_fit[1];
  // app drives pin two as an output only once released, else the resistor wins
  assign o_pin_two = (i_pin_two_free && i_app_out_en) ? i_app_out : i_fit[2];
endmodule : tsbss_strap_board
`default_nettype wire
